// file: hdl/sfc_defs.svh
// constants for the skip and flow control unit
`ifndef SFC_DEFS_SVH
`define SFC_DEFS_SVH

// ***************************************************
// widths
// ***************************************************
`define SFC_PC_W 12
`define SFC_DW 8

// ***************************************************
// reset values
// ***************************************************
`define SFC_PC_RST 12'h000
`define SFC_SP_RST 8'h00
`define SFC_ACC_RST 8'h00
`define SFC_GIE_RST 1'b0

// ***************************************************
// stack and arithmetic steps
// ***************************************************
`define SFC_SP_STEP 8'h02
`define SFC_ONE 8'h01
`define SFC_PC_STEP 12'h001

// ***************************************************
// instruction cycle counts (instruction slots)
// ***************************************************
`define SFC_CYC_LONG 2
`define SFC_CYC_SHORT 1

// ***************************************************
// flag vector bit positions
// ***************************************************
`define SFC_FLAG_Z 0
`define SFC_FLAG_C 1
`define SFC_FLAG_AC 2
`define SFC_FLAG_OV 3

`endif

// file: hdl/sfc_pkg.sv
// types shared by the skip and flow control unit
`default_nettype none
`include "sfc_defs.svh"

package sfc_pkg;

  // ***************************************************
  // operations handed over by the decoder
  // ***************************************************
  typedef enum logic [4:0] {
    OP_NOP,
    OP_NEQ_SKIP_I,
    OP_NEQ_SKIP_M,
    OP_TCLR_SKIP_IO,
    OP_TSET_SKIP_IO,
    OP_TCLR_SKIP_M,
    OP_TSET_SKIP_M,
    OP_INC_SKIP_A,
    OP_DEC_SKIP_A,
    OP_INC_SKIP_M,
    OP_DEC_SKIP_M,
    OP_CALL,
    OP_JUMP,
    OP_RET_VAL,
    OP_RET,
    OP_RETI,
    OP_WDT_CLEAR,
    OP_PC_ADD,
    OP_IDX_MEM,
    OP_OTHER
  } sfc_op_t;

  // ***************************************************
  // execution phase
  // ***************************************************
  typedef enum logic [1:0] {
    PH_RUN,
    PH_WAIT2,
    PH_RET2
  } sfc_phase_t;

  // one instruction as presented by the decoder
  typedef struct packed {
    sfc_op_t op;
    logic [`SFC_DW-1:0] imm;
    logic [2:0] bit_sel;
    logic [`SFC_PC_W-1:0] target;
  } sfc_instr_t;

  // arithmetic result with its flags (ov, ac, c, z)
  typedef struct packed {
    logic [`SFC_DW-1:0] res;
    logic [3:0] flags;
  } sfc_alu_t;

  // whole state of the unit
  typedef struct packed {
    sfc_phase_t phase;
    logic is_reti;
    logic skip_pend;
    logic [`SFC_PC_W-1:0] pc;
    logic [`SFC_DW-1:0] sp;
    logic [`SFC_DW-1:0] acc;
    logic [3:0] flags;
    logic gie;
    logic mem_we;
    logic [`SFC_DW-1:0] mem_wdata;
    logic stk_we;
    logic [`SFC_DW-1:0] stk_addr;
    logic [`SFC_PC_W-1:0] stk_wdata;
    logic wdt_clr;
    logic retire;
    logic skipped;
  } sfc_state_t;

endpackage
`default_nettype wire

// file: hdl/sfc_unit.sv
// skip and flow control unit of the 8-bit core
`timescale 1ns/100ps
`default_nettype none
`include "sfc_defs.svh"

// ***************************************************
// overview
// ***************************************************
// one word is taken per accept; a skip is remembered in a
// pending bit and spent on the next word, which then leaves
// nothing behind but the pc step
// two-slot words hold instr_ready low for exactly one cycle
// the stack itself lives outside; this unit only drives the
// address, the write word and the write pulse
// limitation: a discarded word always costs one slot, even
// when it would have been a two-slot word

module sfc_unit (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // instruction handshake from the decoder
  input wire logic instr_valid,
  output logic instr_ready,
  input wire sfc_pkg::sfc_instr_t instr,
  // operands fetched by the core for the current instruction
  input wire logic [`SFC_DW-1:0] mem_rdata,
  input wire logic [`SFC_DW-1:0] io_rdata,
  input wire logic [`SFC_PC_W-1:0] stk_rdata,
  // global interrupt enable clear from the interrupt controller
  input wire logic gie_clr,
  // architectural state
  output logic [`SFC_PC_W-1:0] pc,
  output logic [`SFC_DW-1:0] sp,
  output logic [`SFC_DW-1:0] acc,
  output logic [3:0] flags,
  output logic gie,
  // memory write-back for the operand byte
  output logic mem_we,
  output logic [`SFC_DW-1:0] mem_wdata,
  // stack word access
  output logic stk_we,
  output logic [`SFC_DW-1:0] stk_addr,
  output logic [`SFC_PC_W-1:0] stk_wdata,
  // side effects and status
  output logic wdt_clr,
  output logic retire,
  output logic skipped
);

  // ***************************************************
  // state
  // ***************************************************
  sfc_pkg::sfc_state_t st_r; // registered state
  sfc_pkg::sfc_state_t st_nxt; // next state
  logic take; // instruction accepted this cycle
  logic sel_io_bit; // selected io bit
  logic sel_mem_bit; // selected memory bit
  sfc_pkg::sfc_alu_t alu_sub_i; // acc minus immediate
  sfc_pkg::sfc_alu_t alu_sub_m; // acc minus memory
  sfc_pkg::sfc_alu_t alu_inc_a; // acc plus one
  sfc_pkg::sfc_alu_t alu_dec_a; // acc minus one
  sfc_pkg::sfc_alu_t alu_inc_m; // memory plus one
  sfc_pkg::sfc_alu_t alu_dec_m; // memory minus one

  // ***************************************************
  // arithmetic helper
  // ***************************************************
  // add or subtract with the four flags; carry means borrow on subtract
  function automatic sfc_pkg::sfc_alu_t alu_op(
    input logic [`SFC_DW-1:0] a,
    input logic [`SFC_DW-1:0] b,
    input logic sub
  );
    sfc_pkg::sfc_alu_t o;
    logic [`SFC_DW:0] full;
    logic [4:0] low;
    // the extra top bit of full is the carry or borrow out;
    // low repeats the sum on the low nibble for the half carry
    o = '0;
    if (sub) begin
      full = {1'b0, a} - {1'b0, b};
      low = {1'b0, a[3:0]} - {1'b0, b[3:0]};
      // overflow: operands of unlike sign and result sign flipped
      o.flags[`SFC_FLAG_OV] = (a[7] != b[7]) && (full[7] != a[7]);
    end else begin
      full = {1'b0, a} + {1'b0, b};
      low = {1'b0, a[3:0]} + {1'b0, b[3:0]};
      // overflow: operands of like sign and result sign flipped
      o.flags[`SFC_FLAG_OV] = (a[7] == b[7]) && (full[7] != a[7]);
    end
    o.res = full[`SFC_DW-1:0];
    o.flags[`SFC_FLAG_C] = full[`SFC_DW];
    o.flags[`SFC_FLAG_AC] = low[4];
    o.flags[`SFC_FLAG_Z] = (full[`SFC_DW-1:0] == 8'h00);
    return o;
  endfunction

  // ***************************************************
  // datapath
  // ***************************************************
  // all candidate results are built in parallel; the case below picks one
  always_comb begin
    alu_sub_i = alu_op(st_r.acc, instr.imm, 1'b1);
    alu_sub_m = alu_op(st_r.acc, mem_rdata, 1'b1);
    alu_inc_a = alu_op(st_r.acc, `SFC_ONE, 1'b0);
    alu_dec_a = alu_op(st_r.acc, `SFC_ONE, 1'b1);
    alu_inc_m = alu_op(mem_rdata, `SFC_ONE, 1'b0);
    alu_dec_m = alu_op(mem_rdata, `SFC_ONE, 1'b1);
    // bit tests index the operand byte with the decoded bit number
    sel_io_bit = io_rdata[instr.bit_sel];
    sel_mem_bit = mem_rdata[instr.bit_sel];
  end

  // ready only between instructions; second slots hold the decoder off
  // a pending skip does not stall; the next word is taken and dropped
  assign instr_ready = (st_r.phase == sfc_pkg::PH_RUN);
  assign take = instr_valid && instr_ready;

  // ***************************************************
  // next-state logic
  // ***************************************************
  always_comb begin
    st_nxt = st_r;
    // pulses last one cycle only
    st_nxt.mem_we = 1'b0;
    st_nxt.stk_we = 1'b0;
    st_nxt.wdt_clr = 1'b0;
    st_nxt.retire = 1'b0;
    st_nxt.skipped = 1'b0;
    // interrupt controller may drop the enable at any time
    // the return-from-interrupt set further down overrides it
    if (gie_clr) begin
      st_nxt.gie = 1'b0;
    end
    // a word only counts when it is taken; in the run phase without take
    // the state simply holds apart from the pulses and the gie clear above
    case (st_r.phase)
      sfc_pkg::PH_RUN: begin
        if (take && st_r.skip_pend) begin
          // discarded word: no side effects, pc steps over it
          st_nxt.skip_pend = 1'b0;
          st_nxt.pc = st_r.pc + `SFC_PC_STEP;
          st_nxt.skipped = 1'b1;
        end else if (take) begin
          // default for short instructions: step pc, retire now
          st_nxt.pc = st_r.pc + `SFC_PC_STEP;
          st_nxt.retire = 1'b1;
          case (instr.op)
            sfc_pkg::OP_NOP: begin
              // only the pc moves
              st_nxt.pc = st_r.pc + `SFC_PC_STEP;
            end
            sfc_pkg::OP_NEQ_SKIP_I: begin
              // flags as for a minus imm, acc left alone
              st_nxt.flags = alu_sub_i.flags;
              st_nxt.skip_pend = (st_r.acc != instr.imm);
            end
            sfc_pkg::OP_NEQ_SKIP_M: begin
              // memory operand form of the same compare
              st_nxt.flags = alu_sub_m.flags;
              st_nxt.skip_pend = (st_r.acc != mem_rdata);
            end
            sfc_pkg::OP_TCLR_SKIP_IO: begin
              // flags untouched by bit tests
              st_nxt.skip_pend = !sel_io_bit;
            end
            sfc_pkg::OP_TSET_SKIP_IO: begin
              st_nxt.skip_pend = sel_io_bit;
            end
            sfc_pkg::OP_TCLR_SKIP_M: begin
              st_nxt.skip_pend = !sel_mem_bit;
            end
            sfc_pkg::OP_TSET_SKIP_M: begin
              st_nxt.skip_pend = sel_mem_bit;
            end
            sfc_pkg::OP_INC_SKIP_A: begin
              // acc written, skip on wrap to zero
              st_nxt.acc = alu_inc_a.res;
              st_nxt.flags = alu_inc_a.flags;
              st_nxt.skip_pend = alu_inc_a.flags[`SFC_FLAG_Z];
            end
            sfc_pkg::OP_DEC_SKIP_A: begin
              st_nxt.acc = alu_dec_a.res;
              st_nxt.flags = alu_dec_a.flags;
              st_nxt.skip_pend = alu_dec_a.flags[`SFC_FLAG_Z];
            end
            sfc_pkg::OP_INC_SKIP_M: begin
              // result goes back to the operand byte
              st_nxt.mem_we = 1'b1;
              st_nxt.mem_wdata = alu_inc_m.res;
              st_nxt.flags = alu_inc_m.flags;
              st_nxt.skip_pend = alu_inc_m.flags[`SFC_FLAG_Z];
            end
            sfc_pkg::OP_DEC_SKIP_M: begin
              st_nxt.mem_we = 1'b1;
              st_nxt.mem_wdata = alu_dec_m.res;
              st_nxt.flags = alu_dec_m.flags;
              st_nxt.skip_pend = alu_dec_m.flags[`SFC_FLAG_Z];
            end
            sfc_pkg::OP_CALL: begin
              // push return address at sp, then move sp up
              // stk_addr is the old sp; the word lands there on the next edge
              st_nxt.stk_we = 1'b1;
              st_nxt.stk_addr = st_r.sp;
              st_nxt.stk_wdata = st_r.pc + `SFC_PC_STEP;
              st_nxt.sp = st_r.sp + `SFC_SP_STEP;
              st_nxt.pc = instr.target;
              st_nxt.retire = 1'b0;
              st_nxt.phase = sfc_pkg::PH_WAIT2;
            end
            sfc_pkg::OP_JUMP: begin
              // full-width target, no flags touched
              // target replaces pc outright; no relative form here
              st_nxt.pc = instr.target;
              st_nxt.retire = 1'b0;
              st_nxt.phase = sfc_pkg::PH_WAIT2;
            end
            sfc_pkg::OP_RET_VAL, sfc_pkg::OP_RET, sfc_pkg::OP_RETI: begin
              // value load happens first, then the ordinary return
              // sp drops now so the read address is ready for the second slot
              if (instr.op == sfc_pkg::OP_RET_VAL) begin
                st_nxt.acc = instr.imm;
              end
              st_nxt.sp = st_r.sp - `SFC_SP_STEP;
              st_nxt.is_reti = (instr.op == sfc_pkg::OP_RETI);
              st_nxt.pc = st_r.pc;
              st_nxt.retire = 1'b0;
              st_nxt.phase = sfc_pkg::PH_RET2;
            end
            sfc_pkg::OP_WDT_CLEAR: begin
              // one pulse to the watchdog counter, nothing else
              st_nxt.wdt_clr = 1'b1;
            end
            sfc_pkg::OP_PC_ADD: begin
              // acc taken unsigned, wraps within program space
              // the base is the pc of this word, as a jump table expects
              st_nxt.pc = st_r.pc + {{(`SFC_PC_W-`SFC_DW){1'b0}}, st_r.acc};
              st_nxt.retire = 1'b0;
              st_nxt.phase = sfc_pkg::PH_WAIT2;
            end
            sfc_pkg::OP_IDX_MEM: begin
              // executed elsewhere; this unit only spends the second slot
              st_nxt.retire = 1'b0;
              st_nxt.phase = sfc_pkg::PH_WAIT2;
            end
            default: begin
              // other instructions: one slot, pc steps
              st_nxt.pc = st_r.pc + `SFC_PC_STEP;
            end
          endcase
        end
      end
      sfc_pkg::PH_WAIT2: begin
        // second slot of a two-cycle instruction
        // pc already holds its final value (the target, or the next word for OP_IDX_MEM); only the retire pulse is left
        st_nxt.retire = 1'b1;
        st_nxt.phase = sfc_pkg::PH_RUN;
      end
      sfc_pkg::PH_RET2: begin
        // sp already points at the saved word; stk_addr shows it
        // the saved word comes back combinationally from the stack
        // limitation: stk_rdata must be valid in this slot, no wait state
        st_nxt.pc = stk_rdata;
        st_nxt.retire = 1'b1;
        st_nxt.phase = sfc_pkg::PH_RUN;
        if (st_r.is_reti) begin
          // set beats a simultaneous clear from the controller
          st_nxt.gie = 1'b1;
        end
        st_nxt.is_reti = 1'b0;
      end
      default: begin
        // unreachable phase code: fall back to run
        st_nxt.phase = sfc_pkg::PH_RUN;
      end
    endcase
    // read address follows sp during the return slot
    if (st_nxt.phase == sfc_pkg::PH_RET2) begin
      st_nxt.stk_addr = st_nxt.sp;
    end
  end

  // ***************************************************
  // state register
  // ***************************************************
  // asynchronous reset to constants only; pulses come up low
  // so nothing downstream sees a stray write after reset
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
      st_r.phase <= sfc_pkg::PH_RUN;
      st_r.pc <= `SFC_PC_RST;
      st_r.sp <= `SFC_SP_RST;
      st_r.acc <= `SFC_ACC_RST;
      st_r.gie <= `SFC_GIE_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ***************************************************
  // outputs, all straight from the state register
  // ***************************************************
  // every output below is a flop, so no path from instr reaches them
  assign pc = st_r.pc;
  assign sp = st_r.sp;
  assign acc = st_r.acc;
  assign flags = st_r.flags;
  assign gie = st_r.gie;
  assign mem_we = st_r.mem_we;
  assign mem_wdata = st_r.mem_wdata;
  assign stk_we = st_r.stk_we;
  assign stk_addr = st_r.stk_addr;
  assign stk_wdata = st_r.stk_wdata;
  assign wdt_clr = st_r.wdt_clr;
  assign retire = st_r.retire;
  assign skipped = st_r.skipped;

endmodule
`default_nettype wire

// file: tb/sfc_unit_props.sv
// port assertions for the skip and flow control unit
`timescale 1ns/100ps
`default_nettype none
`include "sfc_defs.svh"

// ***************************************************
// checker
// ***************************************************
module sfc_unit_props (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // instruction port and operands
  input wire logic instr_valid,
  input wire logic instr_ready,
  input wire sfc_pkg::sfc_instr_t instr,
  input wire logic [`SFC_DW-1:0] mem_rdata,
  input wire logic [`SFC_DW-1:0] io_rdata,
  input wire logic [`SFC_PC_W-1:0] stk_rdata,
  input wire logic gie_clr,
  // architectural state
  input wire logic [`SFC_PC_W-1:0] pc,
  input wire logic [`SFC_DW-1:0] sp,
  input wire logic [`SFC_DW-1:0] acc,
  input wire logic [3:0] flags,
  input wire logic gie,
  // strobes
  input wire logic mem_we,
  input wire logic [`SFC_DW-1:0] mem_wdata,
  input wire logic stk_we,
  input wire logic [`SFC_DW-1:0] stk_addr,
  input wire logic [`SFC_PC_W-1:0] stk_wdata,
  input wire logic wdt_clr,
  input wire logic retire,
  input wire logic skipped
);
  // accepted word; a low skipped one cycle on means it really ran
  logic tk;
  assign tk = instr_valid && instr_ready;

  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  property p_call;
    tk && instr.op == sfc_pkg::OP_CALL ##1 !skipped |-> pc == $past(instr.target) && sp == $past(sp) + 8'h02
      && stk_we && stk_addr == $past(sp) && stk_wdata == $past(pc) + 12'h001;
  endproperty
  a_call: assert property (p_call) else $error("call push or target wrong");
  property p_ret;
    tk && instr.op inside {sfc_pkg::OP_RET, sfc_pkg::OP_RET_VAL, sfc_pkg::OP_RETI} ##1 !skipped
      |-> sp == $past(sp) - 8'h02 && stk_addr == sp ##1 pc == $past(stk_rdata) && retire;
  endproperty
  a_ret: assert property (p_ret) else $error("return pop wrong");
  property p_reti;
    tk && instr.op == sfc_pkg::OP_RETI ##1 !skipped |-> ##1 gie;
  endproperty
  a_reti: assert property (p_reti) else $error("interrupt enable not set");
  // two-slot ops refuse exactly one word and retire late
  property p_slot2;
    tk && instr.op inside {sfc_pkg::OP_CALL, sfc_pkg::OP_JUMP, sfc_pkg::OP_RET, sfc_pkg::OP_RET_VAL,
      sfc_pkg::OP_RETI, sfc_pkg::OP_PC_ADD, sfc_pkg::OP_IDX_MEM} ##1 !skipped
      |-> !instr_ready && !retire ##1 instr_ready && retire;
  endproperty
  a_slot2: assert property (p_slot2) else $error("two-slot timing wrong");
  property p_keepf;
    tk && instr.op inside {sfc_pkg::OP_TCLR_SKIP_IO, sfc_pkg::OP_TSET_SKIP_IO, sfc_pkg::OP_TCLR_SKIP_M,
      sfc_pkg::OP_TSET_SKIP_M, sfc_pkg::OP_NOP, sfc_pkg::OP_JUMP, sfc_pkg::OP_CALL} |=> $stable(flags);
  endproperty
  a_keepf: assert property (p_keepf) else $error("flags changed");
  property p_memw;
    tk && instr.op inside {sfc_pkg::OP_INC_SKIP_M, sfc_pkg::OP_DEC_SKIP_M} ##1 !skipped |-> mem_we
      && mem_wdata == $past(mem_rdata) + ($past(instr.op) == sfc_pkg::OP_INC_SKIP_M ? 8'h01 : 8'hFF);
  endproperty
  a_memw: assert property (p_memw) else $error("memory write-back wrong");
  property p_neq;
    tk && instr.op == sfc_pkg::OP_NEQ_SKIP_I ##1 !skipped |-> $stable(acc)
      && flags[`SFC_FLAG_Z] == ($past(acc) == $past(instr.imm)) && flags[`SFC_FLAG_C] == ($past(acc) < $past(instr.imm));
  endproperty
  a_neq: assert property (p_neq) else $error("compare flags wrong");
  property p_pcadd;
    tk && instr.op == sfc_pkg::OP_PC_ADD ##1 !skipped |-> pc == $past(pc) + {4'h0, $past(acc)};
  endproperty
  a_pcadd: assert property (p_pcadd) else $error("pc add target wrong");
  property p_wdt;
    tk && instr.op == sfc_pkg::OP_WDT_CLEAR ##1 !skipped |-> wdt_clr && $stable(acc) && $stable(flags);
  endproperty
  a_wdt: assert property (p_wdt) else $error("watchdog clear wrong");
  // a discarded word leaves no trace but the pc step
  property p_skipped;
    skipped |-> !mem_we && !stk_we && !wdt_clr && $stable(acc) && $stable(flags) && pc == $past(pc) + 12'h001;
  endproperty
  a_skipped: assert property (p_skipped) else $error("discarded word had effect");
endmodule

bind sfc_unit sfc_unit_props u_props (
  .clk_sys, .rst_n, .instr_valid, .instr_ready, .instr, .mem_rdata, .io_rdata, .stk_rdata, .gie_clr,
  .pc, .sp, .acc, .flags, .gie, .mem_we, .mem_wdata, .stk_we, .stk_addr, .stk_wdata, .wdt_clr, .retire,
  .skipped
);
`default_nettype wire

// file: tb/testbench.sv
// self-checking bench for the skip and flow control unit
`timescale 1ns/100ps
`default_nettype none
`include "sfc_defs.svh"
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin error_cnt++; \
  $display("mismatch %s exp %0h got %0h", n, e, g); end end

module testbench;
  // ***************************************************
  // signals
  // ***************************************************
  logic clk_sys, rst_n, instr_valid, gie_clr, instr_ready, gie, mem_we, stk_we, wdt_clr, retire, skipped;
  sfc_pkg::sfc_instr_t instr;
  logic [`SFC_DW-1:0] mem_rdata, io_rdata, sp, acc, mem_wdata, stk_addr;
  logic [`SFC_PC_W-1:0] stk_rdata, pc, stk_wdata;
  logic [3:0] flags;
  logic [`SFC_PC_W-1:0] stk_mem [256]; // stack memory beside the unit
  int error_cnt, checked;

  sfc_unit DUT (
    .clk_sys, .rst_n, .instr_valid, .instr_ready, .instr, .mem_rdata, .io_rdata, .stk_rdata, .gie_clr,
    .pc, .sp, .acc, .flags, .gie, .mem_we, .mem_wdata, .stk_we, .stk_addr, .stk_wdata, .wdt_clr, .retire,
    .skipped
  );

  // 200 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  // stack words read back combinationally at the unit's address
  assign stk_rdata = stk_mem[stk_addr];
  always @(posedge clk_sys) begin
    if (stk_we) begin
      stk_mem[stk_addr] <= stk_wdata;
    end
  end

  // ***************************************************
  // drivers
  // ***************************************************
  // verdict and end of run
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // offer one word; a gap cycle first keeps valid from toggling twice
  task automatic go(sfc_pkg::sfc_op_t op, logic [7:0] imm, logic [11:0] tgt);
    int n;
    n = 0;
    @(posedge clk_sys);
    #1;
    while (instr_ready !== 1'b1 && n < 20) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    if (instr_ready !== 1'b1) begin
      error_cnt++;
      end_of_test();
    end
    instr = '{op: op, imm: imm, bit_sel: 3'h5, target: tgt};
    instr_valid = 1'b1;
    @(posedge clk_sys);
    #1;
    instr_valid = 1'b0;
  endtask

  // next word is a jump: skipped means pc steps, else it lands
  task automatic follow(logic sk);
    logic [11:0] p;
    p = pc;
    go(sfc_pkg::OP_JUMP, 8'h00, 12'hABC);
    `CHK("skipped", sk, skipped)
    `CHK("pc", sk ? p + 12'h001 : 12'hABC, pc)
  endtask

  // one op with its acc, flags and write-back, then the skip probe
  task automatic op_chk(sfc_pkg::sfc_op_t op, logic [7:0] imm, logic [7:0] a, logic [3:0] f, logic [7:0] w,
      logic sk);
    go(op, imm, 12'h000);
    `CHK("acc", a, acc)
    `CHK("flags", f, flags)
    `CHK("mem_we", op inside {sfc_pkg::OP_INC_SKIP_M, sfc_pkg::OP_DEC_SKIP_M}, mem_we)
    if (mem_we === 1'b1) `CHK("mem_wdata", w, mem_wdata)
    follow(sk);
  endtask

  // ***************************************************
  // scenarios
  // ***************************************************
  task automatic t_nop_wdt();
    go(sfc_pkg::OP_NOP, 8'h00, 12'h000);
    `CHK("pc", 12'h001, pc)
    go(sfc_pkg::OP_WDT_CLEAR, 8'h00, 12'h000);
    `CHK("wdt_clr", 1'b1, wdt_clr)
    `CHK("state", {12'h002, 8'h00, 8'h00, 4'h0}, {pc, sp, acc, flags})
  endtask

  // wrap-around and overflow corners of the accumulator ops
  task automatic t_acc();
    op_chk(sfc_pkg::OP_DEC_SKIP_A, 8'h00, 8'hFF, 4'h6, 8'h00, 1'b0);
    op_chk(sfc_pkg::OP_INC_SKIP_A, 8'h00, 8'h00, 4'h7, 8'h00, 1'b1);
    op_chk(sfc_pkg::OP_INC_SKIP_A, 8'h00, 8'h01, 4'h0, 8'h00, 1'b0);
    op_chk(sfc_pkg::OP_DEC_SKIP_A, 8'h00, 8'h00, 4'h1, 8'h00, 1'b1);
    op_chk(sfc_pkg::OP_NEQ_SKIP_I, 8'h55, 8'h00, 4'h6, 8'h00, 1'b1);
    op_chk(sfc_pkg::OP_NEQ_SKIP_I, 8'h80, 8'h00, 4'hA, 8'h00, 1'b1);
    op_chk(sfc_pkg::OP_NEQ_SKIP_I, 8'h00, 8'h00, 4'h1, 8'h00, 1'b0);
  endtask

  // the tested bit is 5; every other bit and the other source disagree
  task automatic t_bits();
    sfc_pkg::sfc_op_t ops [4];
    ops = '{sfc_pkg::OP_TCLR_SKIP_IO, sfc_pkg::OP_TSET_SKIP_IO, sfc_pkg::OP_TCLR_SKIP_M, sfc_pkg::OP_TSET_SKIP_M};
    for (int i = 0; i < 8; i++) begin
      io_rdata = (i[0] ^ i[2]) ? 8'h20 : 8'hDF;
      mem_rdata = ~io_rdata;
      op_chk(ops[i/2], 8'h00, 8'h00, 4'h1, 8'h00, i[1] == i[0]);
    end
  endtask

  task automatic t_mem();
    mem_rdata = 8'h00;
    op_chk(sfc_pkg::OP_NEQ_SKIP_M, 8'h00, 8'h00, 4'h1, 8'h00, 1'b0);
    mem_rdata = 8'h01;
    op_chk(sfc_pkg::OP_NEQ_SKIP_M, 8'h00, 8'h00, 4'h6, 8'h00, 1'b1);
    mem_rdata = 8'hFF;
    op_chk(sfc_pkg::OP_INC_SKIP_M, 8'h00, 8'h00, 4'h7, 8'h00, 1'b1);
    mem_rdata = 8'h7F;
    op_chk(sfc_pkg::OP_INC_SKIP_M, 8'h00, 8'h00, 4'hC, 8'h80, 1'b0);
    mem_rdata = 8'h01;
    op_chk(sfc_pkg::OP_DEC_SKIP_M, 8'h00, 8'h00, 4'h1, 8'h00, 1'b1);
    mem_rdata = 8'h80;
    op_chk(sfc_pkg::OP_DEC_SKIP_M, 8'h00, 8'h00, 4'hC, 8'h7F, 1'b0);
  endtask

  task automatic t_call_ret();
    logic [11:0] p;
    p = pc;
    go(sfc_pkg::OP_CALL, 8'h00, 12'h9A5);
    `CHK("call", {12'h9A5, 8'h02, 1'b1, 8'h00, p + 12'h001}, {pc, sp, stk_we, stk_addr, stk_wdata})
    `CHK("ready", 1'b0, instr_ready)
    @(posedge clk_sys);
    #1;
    `CHK("retire", 1'b1, retire)
    go(sfc_pkg::OP_RET_VAL, 8'h3C, 12'h000);
    `CHK("acc sp", {8'h3C, 8'h00, 4'hC}, {acc, sp, flags})
    @(posedge clk_sys);
    #1;
    `CHK("pc", p + 12'h001, pc)
  endtask

  task automatic t_pcadd();
    logic [11:0] p;
    p = pc;
    go(sfc_pkg::OP_PC_ADD, 8'h00, 12'h000);
    `CHK("pc", p + 12'h03C, pc)
    `CHK("ready", 1'b0, instr_ready)
  endtask

  task automatic t_reti();
    logic [11:0] p;
    p = pc;
    go(sfc_pkg::OP_CALL, 8'h00, 12'h7F0);
    go(sfc_pkg::OP_RETI, 8'h00, 12'h000);
    `CHK("gie", 1'b0, gie)
    gie_clr = 1'b1; // clear in the return slot: the set wins
    @(posedge clk_sys);
    #1;
    `CHK("gie pc", {1'b1, p + 12'h001}, {gie, pc})
    @(posedge clk_sys);
    #1;
    gie_clr = 1'b0;
    `CHK("gie", 1'b0, gie)
  endtask

  // plain return, and words this unit only counts slots for
  task automatic t_ret2();
    logic [11:0] p;
    p = pc;
    go(sfc_pkg::OP_CALL, 8'h00, 12'h456);
    go(sfc_pkg::OP_OTHER, 8'h00, 12'h000);
    `CHK("other", {12'h457, 1'b1, 1'b1}, {pc, retire, instr_ready})
    go(sfc_pkg::OP_IDX_MEM, 8'h00, 12'h000);
    `CHK("idx", {12'h458, 1'b0, 1'b0}, {pc, retire, instr_ready})
    go(sfc_pkg::OP_RET, 8'h00, 12'h000);
    `CHK("ret", {8'h3C, 8'h00, 1'b0}, {acc, sp, instr_ready})
    @(posedge clk_sys);
    #1;
    `CHK("ret pc", {p + 12'h001, 1'b1}, {pc, retire})
  endtask

  // a taken skip drops a call and a memory increment without trace
  task automatic t_discard();
    sfc_pkg::sfc_op_t ops [2];
    logic [11:0] p;
    ops = '{sfc_pkg::OP_CALL, sfc_pkg::OP_INC_SKIP_M};
    io_rdata = 8'h20;
    foreach (ops[i]) begin
      go(sfc_pkg::OP_TSET_SKIP_IO, 8'h00, 12'h000);
      p = pc;
      go(ops[i], 8'h00, 12'h123);
      `CHK("discard", {1'b1, 1'b0, 1'b0, 8'h00, p + 12'h001}, {skipped, stk_we, mem_we, sp, pc})
    end
  endtask

  // ***************************************************
  // main sequence
  // ***************************************************
  initial begin
    rst_n = 1'b0;
    instr_valid = 1'b0;
    gie_clr = 1'b0;
    instr = '0;
    mem_rdata = 8'h00;
    io_rdata = 8'h00;
    error_cnt = 0;
    checked = 0;
    repeat (8) @(posedge clk_sys);
    #1;
    `CHK("reset", 33'h0, {pc, sp, acc, flags, gie})
    rst_n = 1'b1;
    t_nop_wdt();
    t_acc();
    t_bits();
    t_mem();
    t_call_ret();
    t_pcadd();
    t_reti();
    t_ret2();
    t_discard();
    end_of_test();
  end
endmodule
`default_nettype wire
